// [core/ocpwm_defines.svh]
// Constants for the output compare channel: modes, bit positions, resets.
`ifndef OCPWM_DEFINES_SVH
`define OCPWM_DEFINES_SVH

// ==========================================================================
// Mode codes of the compare mode field
// ==========================================================================
`define OCPWM_MODE_OFF 3'h0
`define OCPWM_MODE_SINGLE 3'h4
`define OCPWM_MODE_CONT 3'h5
`define OCPWM_MODE_PWM_NOFLT 3'h6
`define OCPWM_MODE_PWM_FLT 3'h7

// ==========================================================================
// Bit positions of the compare control register readback
// ==========================================================================
`define OCPWM_CTRL_MODE_MSB 2
`define OCPWM_CTRL_MODE_LSB 0
`define OCPWM_CTRL_TSEL_BIT 3
`define OCPWM_CTRL_FLT_BIT 4

// ==========================================================================
// Reset values
// ==========================================================================
`define OCPWM_CTRL_RST 16'h0000
`define OCPWM_CMP_RST 16'h0000
`define OCPWM_COUNT_RST 16'h0000
`define OCPWM_DUTY_ZERO 16'h0000

// ==========================================================================
// Time base prescale selects and their terminal counts
// ==========================================================================
`define OCPWM_PRE_SEL_1 2'h0
`define OCPWM_PRE_SEL_8 2'h1
`define OCPWM_PRE_SEL_64 2'h2
`define OCPWM_PRE_SEL_256 2'h3
`define OCPWM_PRE_LIM_1 8'h00
`define OCPWM_PRE_LIM_8 8'h07
`define OCPWM_PRE_LIM_64 8'h3F
`define OCPWM_PRE_LIM_256 8'hFF
`define OCPWM_PRE_RST 8'h00

`endif

// [core/ocpwm_pkg.sv]
// Types shared by the output compare channel and its time bases.
package ocpwm_pkg;

  typedef logic [15:0] ocpwm_word_t;

  typedef enum logic [1:0] {
    ocpwm_idle,
    ocpwm_wait_rise,
    ocpwm_wait_fall,
    ocpwm_done
  } ocpwm_state_t;

endpackage

// [core/ocpwm_time_base.sv]
// One 16-bit time base with prescaler and period wrap.
`timescale 1ns/10ps
`default_nettype none
`include "ocpwm_defines.svh"

module ocpwm_time_base
  import ocpwm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [1:0] prescale_in,
  input wire logic [15:0] period_in,
  output logic [15:0] count_out,
  output logic step_out,
  output logic wrap_out
);

  logic [7:0] pre_cnt_r;
  logic [7:0] pre_lim;
  logic tick;
  ocpwm_word_t count_r;
  logic step_r;
  logic wrap_r;

  // ========================================================================
  // Prescaler
  // ========================================================================
  always_comb begin
    unique case (prescale_in)
      `OCPWM_PRE_SEL_1: pre_lim = `OCPWM_PRE_LIM_1;
      `OCPWM_PRE_SEL_8: pre_lim = `OCPWM_PRE_LIM_8;
      `OCPWM_PRE_SEL_64: pre_lim = `OCPWM_PRE_LIM_64;
      `OCPWM_PRE_SEL_256: pre_lim = `OCPWM_PRE_LIM_256;
    endcase
  end

  assign tick = run_in && (pre_cnt_r >= pre_lim);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pre_cnt_r <= `OCPWM_PRE_RST;
    end else if (!run_in || tick) begin
      pre_cnt_r <= `OCPWM_PRE_RST;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // ========================================================================
  // Counter
  // ========================================================================
  // A count equal to the period returns to zero, so N gives N+1 counts.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count_r <= `OCPWM_COUNT_RST;
      step_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      step_r <= tick;
      wrap_r <= tick && (count_r == period_in);
      if (tick) begin
        if (count_r == period_in) begin
          count_r <= `OCPWM_COUNT_RST;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end

  assign count_out = count_r;
  assign step_out = step_r;
  assign wrap_out = wrap_r;

endmodule // ocpwm_time_base

`default_nettype wire

// [core/ocpwm_output_compare.sv]
// Output compare channel: single pulse, continuous pulse and PWM modes.
//
// Functional notes
// - Writing mode 100 drives the pin low and arms one pulse.
// - In pulse modes the primary match drives the pin high.
// - Single mode: secondary match drives low; pin stays low afterwards.
// - Secondary match ending a pulse sets flag; request only when enabled.
// - Mode 101 starts low, then pulses every period, primary to secondary.
// - Timer count equal to period returns to zero and keeps counting.
// - Continuous mode sets the flag on every secondary match that ends a pulse.
// - Control bit 3 picks which of two timers feeds the compare.
// - In PWM the primary value is the duty; software writes ignored.
// - Secondary value loads into the duty only at period match.
// - Primary value at PWM enable sets the first period's duty.
// - Period N gives N+1 counts, each one prescaled instruction cycle.
// - PWM duty zero holds the pin low all period.
// - PWM duty above period holds the pin high continuously.
// - PWM duty equal to period gives exactly one low count.
// - Mode 111 is PWM with fault, 110 without, 000 disabled.
// - A fault in mode 111 sets a status bit only hardware clears.
`timescale 1ns/10ps
`default_nettype none
`include "ocpwm_defines.svh"

module ocpwm_output_compare
  import ocpwm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Control register write.
  input wire logic ctrl_wr_in,
  input wire logic [2:0] compare_mode_field_in,
  input wire logic timer_source_select_in,
  // Compare value writes.
  input wire logic primary_wr_in,
  input wire logic [15:0] primary_data_in,
  input wire logic secondary_wr_in,
  input wire logic [15:0] secondary_data_in,
  // Time base A (select 0) and B (select 1).
  input wire logic timer_a_run_bit_in,
  input wire logic [1:0] timer_a_prescale_in,
  input wire logic [15:0] timer_a_period_in,
  input wire logic timer_b_run_bit_in,
  input wire logic [1:0] timer_b_prescale_in,
  input wire logic [15:0] timer_b_period_in,
  // Fault pin, active low, and interrupt controls.
  input wire logic pwm_fault_n_in,
  input wire logic compare_irq_enable_in,
  input wire logic compare_irq_flag_clr_in,
  output logic compare_output_pin_out,
  output logic compare_irq_flag_out,
  output logic compare_irq_req_out,
  output logic pwm_fault_status_out,
  output logic [15:0] compare_control_reg_out,
  output logic [15:0] primary_compare_value_out,
  output logic [15:0] secondary_compare_value_out,
  output logic [15:0] timer_a_count_out,
  output logic [15:0] timer_b_count_out
);

  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  logic tsel_r;
  logic tsel_nxt;
  ocpwm_state_t state_r;
  ocpwm_word_t primary_r;
  ocpwm_word_t secondary_r;
  logic pin_r;
  logic flag_r;
  logic flag_nxt;
  logic irq_req_r;
  logic fault_r;
  logic fault_nxt;
  logic [15:0] ctrl_rd_r;
  logic [15:0] a_count;
  logic [15:0] b_count;
  logic a_step;
  logic b_step;
  logic a_wrap;
  logic b_wrap;
  ocpwm_word_t sel_count;
  logic sel_step;
  logic sel_wrap;
  logic pulse_mode;
  logic pwm_mode;
  logic pri_hit;
  logic sec_hit;
  logic fault_hit;
  logic fall_event;

  // ========================================================================
  // Time bases
  // ========================================================================
  ocpwm_time_base u_time_base_a (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(timer_a_run_bit_in),
    .prescale_in(timer_a_prescale_in),
    .period_in(timer_a_period_in),
    .count_out(a_count),
    .step_out(a_step),
    .wrap_out(a_wrap)
  );

  ocpwm_time_base u_time_base_b (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(timer_b_run_bit_in),
    .prescale_in(timer_b_prescale_in),
    .period_in(timer_b_period_in),
    .count_out(b_count),
    .step_out(b_step),
    .wrap_out(b_wrap)
  );

  assign timer_a_count_out = a_count;
  assign timer_b_count_out = b_count;

  // ========================================================================
  // Timer selection and match detection
  // ========================================================================
  always_comb begin
    if (tsel_r) begin
      sel_count = b_count;
      sel_step = b_step;
      sel_wrap = b_wrap;
    end else begin
      sel_count = a_count;
      sel_step = a_step;
      sel_wrap = a_wrap;
    end
  end

  // Values the control fields take at this edge, for readback and fault.
  assign mode_nxt = ctrl_wr_in ? compare_mode_field_in : mode_r;
  assign tsel_nxt = ctrl_wr_in ? timer_source_select_in : tsel_r;

  assign pulse_mode = (mode_r == `OCPWM_MODE_SINGLE) ||
                      (mode_r == `OCPWM_MODE_CONT);
  assign pwm_mode = (mode_r == `OCPWM_MODE_PWM_NOFLT) ||
                    (mode_r == `OCPWM_MODE_PWM_FLT);

  // Matches count only on the cycle the selected count has just moved.
  assign pri_hit = sel_step && (sel_count == primary_r);
  assign sec_hit = sel_step && (sel_count == secondary_r);
  assign fault_hit = (mode_r == `OCPWM_MODE_PWM_FLT) && !pwm_fault_n_in;
  assign fall_event = pulse_mode && !ctrl_wr_in &&
                      (state_r == ocpwm_wait_fall) && sec_hit;

  // ========================================================================
  // Control register
  // ========================================================================
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mode_r <= `OCPWM_MODE_OFF;
      tsel_r <= 1'b0;
    end else if (ctrl_wr_in) begin
      mode_r <= compare_mode_field_in;
      tsel_r <= timer_source_select_in;
    end
  end

  // ========================================================================
  // Pulse sequencer
  // ========================================================================
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_r <= ocpwm_idle;
    end else if (ctrl_wr_in) begin
      if ((compare_mode_field_in == `OCPWM_MODE_SINGLE) ||
          (compare_mode_field_in == `OCPWM_MODE_CONT)) begin
        state_r <= ocpwm_wait_rise;
      end else begin
        state_r <= ocpwm_idle;
      end
    end else if (!pulse_mode) begin
      state_r <= ocpwm_idle;
    end else begin
      unique case (state_r)
        ocpwm_wait_rise: begin
          if (pri_hit) begin
            state_r <= ocpwm_wait_fall;
          end
        end
        ocpwm_wait_fall: begin
          if (sec_hit) begin
            if (mode_r == `OCPWM_MODE_SINGLE) begin
              state_r <= ocpwm_done;
            end else begin
              state_r <= ocpwm_wait_rise;
            end
          end
        end
        ocpwm_idle: state_r <= ocpwm_idle;
        ocpwm_done: state_r <= ocpwm_done;
      endcase
    end
  end

  // ========================================================================
  // Output pin
  // ========================================================================
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pin_r <= 1'b0;
    end else if (ctrl_wr_in) begin
      if ((compare_mode_field_in == `OCPWM_MODE_PWM_NOFLT) ||
          (compare_mode_field_in == `OCPWM_MODE_PWM_FLT)) begin
        pin_r <= (primary_r != `OCPWM_DUTY_ZERO);
      end else begin
        pin_r <= 1'b0;
      end
    end else if (pulse_mode) begin
      if ((state_r == ocpwm_wait_rise) && pri_hit) begin
        pin_r <= 1'b1;
      end else if ((state_r == ocpwm_wait_fall) && sec_hit) begin
        pin_r <= 1'b0;
      end
    end else if (pwm_mode) begin
      if (fault_hit || fault_r) begin
        pin_r <= 1'b0;
      end else if (sel_wrap) begin
        // New period starts with the duty just loaded from the buffer.
        pin_r <= (secondary_r != `OCPWM_DUTY_ZERO);
      end else if (pri_hit) begin
        pin_r <= 1'b0;
      end
    end else begin
      pin_r <= 1'b0;
    end
  end

  // ========================================================================
  // Compare values
  // ========================================================================
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      primary_r <= `OCPWM_CMP_RST;
    end else if (pwm_mode) begin
      if (sel_wrap) begin
        primary_r <= secondary_r;
      end
    end else if (primary_wr_in) begin
      primary_r <= primary_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      secondary_r <= `OCPWM_CMP_RST;
    end else if (secondary_wr_in) begin
      secondary_r <= secondary_data_in;
    end
  end

  // ========================================================================
  // Fault status
  // ========================================================================
  // Cleared only by hardware: at a period match with the fault gone,
  // or when the channel leaves the fault-enabled mode.
  always_comb begin
    fault_nxt = fault_r;
    if ((mode_nxt != `OCPWM_MODE_PWM_FLT) ||
        (sel_wrap && pwm_fault_n_in)) begin
      fault_nxt = 1'b0;
    end
    if (fault_hit && (mode_nxt == `OCPWM_MODE_PWM_FLT)) begin
      fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // ========================================================================
  // Interrupt flag and request
  // ========================================================================
  always_comb begin
    flag_nxt = flag_r;
    if (compare_irq_flag_clr_in) begin
      flag_nxt = 1'b0;
    end
    if (fall_event || (fault_hit && !fault_r)) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      flag_r <= 1'b0;
      irq_req_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_req_r <= flag_nxt && compare_irq_enable_in;
    end
  end

  // ========================================================================
  // Control readback
  // ========================================================================
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_rd_r <= `OCPWM_CTRL_RST;
    end else begin
      ctrl_rd_r <= `OCPWM_CTRL_RST;
      ctrl_rd_r[`OCPWM_CTRL_MODE_MSB:`OCPWM_CTRL_MODE_LSB] <= mode_nxt;
      ctrl_rd_r[`OCPWM_CTRL_TSEL_BIT] <= tsel_nxt;
      ctrl_rd_r[`OCPWM_CTRL_FLT_BIT] <= fault_nxt;
    end
  end

  assign compare_output_pin_out = pin_r;
  assign compare_irq_flag_out = flag_r;
  assign compare_irq_req_out = irq_req_r;
  assign pwm_fault_status_out = fault_r;
  assign compare_control_reg_out = ctrl_rd_r;
  assign primary_compare_value_out = primary_r;
  assign secondary_compare_value_out = secondary_r;

endmodule // ocpwm_output_compare

`default_nettype wire

// [bench/ocpwm_output_compare_sva.sv]
// Assertions for the output compare channel, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_output_compare_chk (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ctrl_wr_in,
  input wire logic [2:0] compare_mode_field_in,
  input wire logic primary_wr_in,
  input wire logic pwm_fault_n_in,
  input wire logic compare_irq_enable_in,
  input wire logic compare_output_pin_out,
  input wire logic compare_irq_flag_out,
  input wire logic compare_irq_req_out,
  input wire logic pwm_fault_status_out,
  input wire logic [15:0] compare_control_reg_out,
  input wire logic [15:0] primary_compare_value_out,
  input wire logic [15:0] secondary_compare_value_out,
  input wire logic [15:0] timer_a_count_out,
  input wire logic [15:0] timer_b_count_out
);
  logic [15:0] sel_cnt;
  logic pulse_md;
  logic pwm_md;
  assign sel_cnt = compare_control_reg_out[3] ? timer_b_count_out
                                              : timer_a_count_out;
  assign pulse_md = compare_control_reg_out[2:1] == 2'h2;
  assign pwm_md = compare_control_reg_out[2:1] == 2'h3;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_mode_init;
    ctrl_wr_in && compare_mode_field_in[2:1] == 2'h2
      |=> !compare_output_pin_out;
  endproperty
  property p_off;
    ctrl_wr_in && compare_mode_field_in == 3'h0
      |=> !compare_output_pin_out [*3];
  endproperty
  property p_rise;
    $rose(compare_output_pin_out) && pulse_md && !$past(ctrl_wr_in)
      |-> $past(sel_cnt) == primary_compare_value_out;
  endproperty
  property p_fall;
    $fell(compare_output_pin_out) && pulse_md && !$past(ctrl_wr_in)
      |-> compare_irq_flag_out
          && $past(sel_cnt) == secondary_compare_value_out;
  endproperty
  property p_req;
    $rose(compare_irq_flag_out)
      |-> compare_irq_req_out == $past(compare_irq_enable_in);
  endproperty
  property p_pri_ro;
    primary_wr_in && pwm_md && !ctrl_wr_in && sel_cnt != 16'h0000
      |=> $stable(primary_compare_value_out);
  endproperty
  property p_dbuf;
    $changed(primary_compare_value_out) && $past(pwm_md)
      |-> primary_compare_value_out == $past(secondary_compare_value_out)
          && $past(sel_cnt) == 16'h0000;
  endproperty
  property p_pwm_fall;
    $fell(compare_output_pin_out) && pwm_md && !pwm_fault_status_out
      && !$past(ctrl_wr_in)
      |-> $past(sel_cnt) == primary_compare_value_out;
  endproperty
  property p_fault;
    compare_control_reg_out[2:0] == 3'h7 && !ctrl_wr_in && !pwm_fault_n_in
      |=> !compare_output_pin_out && pwm_fault_status_out
          && compare_control_reg_out[4];
  endproperty
  a_mode_init: assert property (p_mode_init)
    else $error("pin not low after pulse mode write");
  a_off: assert property (p_off)
    else $error("pin not low while disabled");
  a_rise: assert property (p_rise)
    else $error("pulse rise without primary match");
  a_fall: assert property (p_fall)
    else $error("pulse fall without secondary match and flag");
  a_req: assert property (p_req)
    else $error("request does not follow enable");
  a_pri_ro: assert property (p_pri_ro)
    else $error("primary written in pwm mode");
  a_dbuf: assert property (p_dbuf)
    else $error("duty loaded outside period match");
  a_pwm_fall: assert property (p_pwm_fall)
    else $error("pwm fall away from duty count");
  a_fault: assert property (p_fault)
    else $error("fault did not force pin low");
  c_fall: cover property (p_fall);
  c_fault: cover property (p_fault);
  c_pri_ro: cover property (p_pri_ro);
endmodule // ocpwm_output_compare_chk
bind ocpwm_output_compare ocpwm_output_compare_chk u_chk (.*);
`default_nettype wire

// [bench/ocpwm_load_model.sv]
// Load on the compare pin: counts high cycles and rising edges.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_load_model (
  input wire logic core_clk_in,
  input wire logic clr_in,
  input wire logic pin_in,
  output logic [15:0] high_cnt_out,
  output logic [15:0] rise_cnt_out
);
  logic pin_r;
  always_ff @(posedge core_clk_in) begin
    pin_r <= pin_in;
    if (clr_in) begin
      high_cnt_out <= 16'h0000;
      rise_cnt_out <= 16'h0000;
    end else begin
      high_cnt_out <= high_cnt_out + {15'h0000, pin_in};
      rise_cnt_out <= rise_cnt_out + {15'h0000, pin_in & ~pin_r};
    end
  end
endmodule // ocpwm_load_model
`default_nettype wire

// [bench/tb_ocpwm_output_compare.sv]
// Self-checking testbench for the output compare channel.
`timescale 1ns/10ps
`default_nettype none
module tb_ocpwm_output_compare;
  import ocpwm_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ctrl_wr_in = 1'b0;
  logic timer_source_select_in = 1'b0;
  logic primary_wr_in = 1'b0;
  logic secondary_wr_in = 1'b0;
  logic timer_a_run_bit_in = 1'b0;
  logic timer_b_run_bit_in = 1'b1;
  logic pwm_fault_n_in = 1'b1;
  logic compare_irq_enable_in = 1'b1;
  logic compare_irq_flag_clr_in = 1'b0;
  logic clr = 1'b0;
  logic [2:0] compare_mode_field_in = 3'h0;
  logic [1:0] timer_a_prescale_in = 2'h0;
  logic [1:0] timer_b_prescale_in = 2'h0;
  ocpwm_word_t primary_data_in = 16'h0000;
  ocpwm_word_t secondary_data_in = 16'h0000;
  ocpwm_word_t timer_a_period_in = 16'h0009;
  ocpwm_word_t timer_b_period_in = 16'h0013;
  logic compare_output_pin_out, compare_irq_flag_out;
  logic compare_irq_req_out, pwm_fault_status_out;
  ocpwm_word_t compare_control_reg_out, primary_compare_value_out;
  ocpwm_word_t secondary_compare_value_out, timer_a_count_out;
  ocpwm_word_t timer_b_count_out, hi, ri;
  int fails = 0;
  int n_tests = 0;
  int cyc_n = 0;

  ocpwm_output_compare u_dut (.*);
  ocpwm_load_model u_load (.core_clk_in, .clr_in(clr),
    .pin_in(compare_output_pin_out), .high_cnt_out(hi), .rise_cnt_out(ri));

  always #5 core_clk_in = ~core_clk_in;

  // ========================================================================
  // Access tasks.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wr_ctrl(input logic [2:0] m, input logic s);
    @(negedge core_clk_in);
    compare_mode_field_in = m;
    timer_source_select_in = s;
    ctrl_wr_in = 1'b1;
    @(negedge core_clk_in);
    ctrl_wr_in = 1'b0;
    check(compare_control_reg_out, {12'h000, s, m});
  endtask
  task automatic wr_cmp(input logic sec, input ocpwm_word_t v);
    @(negedge core_clk_in);
    primary_wr_in = ~sec;
    secondary_wr_in = sec;
    primary_data_in = v;
    secondary_data_in = v;
    @(negedge core_clk_in);
    primary_wr_in = 1'b0;
    secondary_wr_in = 1'b0;
  endtask
  task automatic lclr();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask
  task automatic flag_clr();
    compare_irq_flag_clr_in = 1'b1;
    cyc(1);
    compare_irq_flag_clr_in = 1'b0;
  endtask
  task automatic run_a(input ocpwm_word_t e_hi, input ocpwm_word_t e_ri);
    lclr();
    timer_a_run_bit_in = 1'b1;
    cyc(30);
    check(hi, e_hi);
    check(ri, e_ri);
  endtask
  task automatic pwm_step(input ocpwm_word_t v, input ocpwm_word_t e_hi,
                          input ocpwm_word_t e_ri);
    wr_cmp(1'b1, v);
    check(secondary_compare_value_out, v);
    cyc(40);
    lclr();
    cyc(64);
    check(hi, e_hi);
    check(ri, e_ri);
  endtask
  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      fails++;
      close_out();
    end
  end

  // ========================================================================
  // Test sequence.
  initial begin
    cyc(20);
    rst_n_in = 1'b1;
    cyc(1);
    check({12'h000, compare_output_pin_out, compare_irq_flag_out,
           compare_irq_req_out, pwm_fault_status_out}, 16'h0000);
    check(compare_control_reg_out, 16'h0000);
    wr_cmp(1'b0, 16'h0002);
    wr_cmp(1'b1, 16'h0005);
    wr_ctrl(3'h4, 1'b0);
    check({15'h0000, compare_output_pin_out}, 16'h0000);
    run_a(16'h0003, 16'h0001);
    check({14'h0000, compare_irq_flag_out, compare_irq_req_out},
          16'h0003);
    check(timer_a_count_out, 16'h0000);
    flag_clr();
    compare_irq_enable_in = 1'b0;
    timer_a_run_bit_in = 1'b0;
    wr_ctrl(3'h4, 1'b0);
    run_a(16'h0003, 16'h0001);
    check({14'h0000, compare_irq_flag_out, compare_irq_req_out},
          16'h0002);
    compare_irq_enable_in = 1'b1;
    wr_cmp(1'b0, 16'h0003);
    wr_cmp(1'b1, 16'h0008);
    wr_ctrl(3'h5, 1'b1);
    check({15'h0000, compare_output_pin_out}, 16'h0000);
    cyc(25);
    lclr();
    cyc(60);
    check(hi, 16'h000F);
    check(ri, 16'h0003);
    flag_clr();
    cyc(20);
    check({15'h0000, compare_irq_flag_out}, 16'h0001);
    rst_n_in = 1'b0;
    timer_a_run_bit_in = 1'b0;
    timer_a_prescale_in = 2'h1;
    timer_a_period_in = 16'h0003;
    cyc(2);
    rst_n_in = 1'b1;
    check({timer_a_count_out[7:0], timer_b_count_out[7:0]}, 16'h0000);
    wr_cmp(1'b0, 16'h0002);
    wr_ctrl(3'h6, 1'b0);
    check({15'h0000, compare_output_pin_out}, 16'h0001);
    timer_a_run_bit_in = 1'b1;
    pwm_step(16'h0002, 16'h0020, 16'h0002);
    wr_cmp(1'b0, 16'h0007);
    check(primary_compare_value_out, 16'h0002);
    pwm_step(16'h0000, 16'h0000, 16'h0000);
    check(primary_compare_value_out, 16'h0000);
    pwm_step(16'h0004, 16'h0040, 16'h0000);
    pwm_step(16'h0003, 16'h0030, 16'h0002);
    wr_ctrl(3'h7, 1'b0);
    cyc(5);
    pwm_fault_n_in = 1'b0;
    cyc(40);
    check({12'h000, compare_output_pin_out, pwm_fault_status_out,
           compare_control_reg_out[4], compare_irq_flag_out},
          16'h0007);
    pwm_fault_n_in = 1'b1;
    cyc(40);
    check({14'h0000, pwm_fault_status_out, compare_control_reg_out[4]},
          16'h0000);
    pwm_fault_n_in = 1'b0;
    wr_ctrl(3'h6, 1'b0);
    pwm_step(16'h0003, 16'h0030, 16'h0002);
    pwm_fault_n_in = 1'b1;
    wr_ctrl(3'h0, 1'b0);
    lclr();
    cyc(40);
    check(hi, 16'h0000);
    close_out();
  end
endmodule // tb_ocpwm_output_compare
`default_nettype wire
